// File: pkg/lcpb_pkg.sv
// constants, types and decode functions of the light curtain parameter bank
package lcpb_pkg;

    // parameter indices; byte address is four times the index
    localparam logic [7:0] LCPB_IDX_CYCLE = 8'h44; // measurement_cycle_time
    localparam logic [7:0] LCPB_IDX_GEN = 8'h47; // general_scan_settings
    localparam logic [7:0] LCPB_IDX_VAR = 8'h5A; // interface_variant_select
    localparam logic [7:0] LCPB_IDX_CAN = 8'h5B; // can_link_settings
    localparam logic [7:0] LCPB_IDX_PB = 8'h5C; // fieldbus_link_settings

    // field positions inside the records
    localparam int LCPB_GEN_MODE_LSB = 24; // scan_geometry_select
    localparam int LCPB_GEN_DIR_LSB = 16; // beam_numbering_order
    localparam int LCPB_GEN_OBJ_LSB = 8; // min_object_filter
    localparam int LCPB_GEN_GAP_LSB = 0; // min_gap_filter
    localparam int LCPB_CAN_RATE_LSB = 8; // can_rate_code
    localparam int LCPB_CAN_NODE_LSB = 0; // can_node_number
    localparam int LCPB_PB_RATE_LSB = 8; // fieldbus_rate_code
    localparam int LCPB_PB_ADDR_LSB = 0; // fieldbus_station_address

    // values after reset
    localparam logic [15:0] LCPB_CYCLE_TIME = 16'h03E8; // fixed, read only
    localparam logic [31:0] LCPB_RST_VAR = 32'h0000_0001;
    localparam logic [7:0] LCPB_RST_MODE = 8'h00;
    localparam logic [7:0] LCPB_RST_DIR = 8'h00;
    localparam logic [7:0] LCPB_RST_OBJ = 8'h01;
    localparam logic [7:0] LCPB_RST_GAP = 8'h01;
    localparam logic [7:0] LCPB_RST_CAN_RATE = 8'h00;
    localparam logic [7:0] LCPB_RST_CAN_NODE = 8'h0A;
    localparam logic [7:0] LCPB_RST_PB_RATE = 8'h06;
    localparam logic [7:0] LCPB_RST_PB_ADDR = 8'h7E;

    // legal ranges of the writable fields
    localparam logic [31:0] LCPB_VAR_MIN = 32'h0000_0001;
    localparam logic [31:0] LCPB_VAR_MAX = 32'h0000_0007;
    localparam logic [7:0] LCPB_MODE_MAX = 8'h02;
    localparam logic [7:0] LCPB_DIR_MAX = 8'h01;
    localparam logic [7:0] LCPB_FILT_MIN = 8'h01;
    localparam logic [7:0] LCPB_CAN_RATE_MAX = 8'h03;
    localparam logic [7:0] LCPB_CAN_NODE_MIN = 8'h01;
    localparam logic [7:0] LCPB_CAN_NODE_MAX = 8'h7F;
    localparam logic [7:0] LCPB_PB_RATE_MAX = 8'h07;
    localparam logic [7:0] LCPB_PB_ADDR_MIN = 8'h01;
    localparam logic [7:0] LCPB_PB_ADDR_MAX = 8'h7E;
    localparam logic [3:0] LCPB_STRB_ALL = 4'hF; // records only as whole

    // which parameter an access aims at
    typedef enum logic [2:0] {
        LCPB_TGT_NONE = 3'b000,
        LCPB_TGT_CYC = 3'b001,
        LCPB_TGT_GEN = 3'b010,
        LCPB_TGT_VAR = 3'b011,
        LCPB_TGT_CAN = 3'b100,
        LCPB_TGT_PB = 3'b101
    } lcpb_tgt_t;

    // bus slave phase
    typedef enum logic [0:0] {
        LCPB_ST_IDLE = 1'b0,
        LCPB_ST_ANSWER = 1'b1
    } lcpb_st_t;

    // byte address of a parameter index
    function automatic logic [11:0] lcpb_byte_addr(input logic [7:0] idx);
        lcpb_byte_addr = {2'b00, idx, 2'b00};
    endfunction

    // can bit-rate code to kbit/s
    function automatic logic [10:0] lcpb_can_kbps(input logic [7:0] code);
        case (code)
            8'h00: lcpb_can_kbps = 11'h3E8;
            8'h01: lcpb_can_kbps = 11'h1F4;
            8'h02: lcpb_can_kbps = 11'h0FA;
            8'h03: lcpb_can_kbps = 11'h07D;
            default: lcpb_can_kbps = 11'h000;
        endcase
    endfunction

    // fieldbus bit-rate code to bit/s
    function automatic logic [21:0] lcpb_pb_bps(input logic [7:0] code);
        case (code)
            8'h00: lcpb_pb_bps = 22'h002580;
            8'h01: lcpb_pb_bps = 22'h004B00;
            8'h02: lcpb_pb_bps = 22'h00B18A;
            8'h03: lcpb_pb_bps = 22'h016E36;
            8'h04: lcpb_pb_bps = 22'h02DC6C;
            8'h05: lcpb_pb_bps = 22'h07A120;
            8'h06: lcpb_pb_bps = 22'h16E360;
            8'h07: lcpb_pb_bps = 22'h2DC6C0;
            default: lcpb_pb_bps = 22'h000000;
        endcase
    endfunction

endpackage

// File: pkg/lcpb_cfg_if.sv
// write request and stored fields between bus front end and parameter store
`timescale 1ns/100ps
interface lcpb_cfg_if;
    import lcpb_pkg::*;
    logic wr_stb; // commit a whole-record write this cycle
    lcpb_tgt_t wr_tgt; // record the access aims at
    logic [31:0] wdata; // record image being written
    logic wr_ok; // image is legal for that record
    logic [7:0] gen_mode; // stored fields
    logic [7:0] gen_dir;
    logic [7:0] gen_obj;
    logic [7:0] gen_gap;
    logic [31:0] var_sel;
    logic [7:0] can_rate;
    logic [7:0] can_node;
    logic [7:0] pb_rate;
    logic [7:0] pb_addr;

    modport bank (
        output wr_stb, wr_tgt, wdata,
        input wr_ok, gen_mode, gen_dir, gen_obj, gen_gap, var_sel,
        input can_rate, can_node, pb_rate, pb_addr
    );
    modport store (
        input wr_stb, wr_tgt, wdata,
        output wr_ok, gen_mode, gen_dir, gen_obj, gen_gap, var_sel,
        output can_rate, can_node, pb_rate, pb_addr
    );
endinterface

// File: core/lcpb_store.sv
// parameter store with range check of whole-record writes
`timescale 1ns/100ps
module lcpb_store
    import lcpb_pkg::*;
(
    input wire logic mclk_in, // 50 MHz
    input wire logic nrst_in, // async, active low
    lcpb_cfg_if.store cfg // request in, fields out
);
    // field slices of the incoming image
    wire [7:0] w_mode = cfg.wdata[LCPB_GEN_MODE_LSB +: 8];
    wire [7:0] w_dir = cfg.wdata[LCPB_GEN_DIR_LSB +: 8];
    wire [7:0] w_obj = cfg.wdata[LCPB_GEN_OBJ_LSB +: 8];
    wire [7:0] w_gap = cfg.wdata[LCPB_GEN_GAP_LSB +: 8];
    wire [7:0] w_crate = cfg.wdata[LCPB_CAN_RATE_LSB +: 8];
    wire [7:0] w_cnode = cfg.wdata[LCPB_CAN_NODE_LSB +: 8];
    wire [7:0] w_prate = cfg.wdata[LCPB_PB_RATE_LSB +: 8];
    wire [7:0] w_paddr = cfg.wdata[LCPB_PB_ADDR_LSB +: 8];

    // one check per record; any bad field spoils the whole record
    wire gen_ok = (w_mode <= LCPB_MODE_MAX) && (w_dir <= LCPB_DIR_MAX) &&
        (w_obj >= LCPB_FILT_MIN) && (w_gap >= LCPB_FILT_MIN);
    wire var_ok = (cfg.wdata >= LCPB_VAR_MIN) &&
        (cfg.wdata <= LCPB_VAR_MAX);
    wire can_ok = (w_crate <= LCPB_CAN_RATE_MAX) &&
        (w_cnode >= LCPB_CAN_NODE_MIN) &&
        (w_cnode <= LCPB_CAN_NODE_MAX);
    wire pb_ok = (w_prate <= LCPB_PB_RATE_MAX) &&
        (w_paddr >= LCPB_PB_ADDR_MIN) &&
        (w_paddr <= LCPB_PB_ADDR_MAX);

    // read-only and unmapped targets never accept a write
    assign cfg.wr_ok = (cfg.wr_tgt == LCPB_TGT_GEN) ? gen_ok :
        (cfg.wr_tgt == LCPB_TGT_VAR) ? var_ok :
        (cfg.wr_tgt == LCPB_TGT_CAN) ? can_ok :
        (cfg.wr_tgt == LCPB_TGT_PB) ? pb_ok : 1'b0;

    wire take = cfg.wr_stb && cfg.wr_ok; // rejected writes keep old values
    wire take_gen = take && (cfg.wr_tgt == LCPB_TGT_GEN);
    wire take_var = take && (cfg.wr_tgt == LCPB_TGT_VAR);
    wire take_can = take && (cfg.wr_tgt == LCPB_TGT_CAN);
    wire take_pb = take && (cfg.wr_tgt == LCPB_TGT_PB);

    logic [7:0] mode_ff, dir_ff, obj_ff, gap_ff; // general record
    logic [31:0] var_ff; // interface variant
    logic [7:0] crate_ff, cnode_ff, prate_ff, paddr_ff; // link records

    // general record, written only as a whole
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            mode_ff <= LCPB_RST_MODE;
            dir_ff <= LCPB_RST_DIR;
            obj_ff <= LCPB_RST_OBJ;
            gap_ff <= LCPB_RST_GAP;
        end
        else if (take_gen)
        begin
            mode_ff <= w_mode;
            dir_ff <= w_dir;
            obj_ff <= w_obj;
            gap_ff <= w_gap;
        end
    end

    // variant selector and both link records
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            var_ff <= LCPB_RST_VAR;
            crate_ff <= LCPB_RST_CAN_RATE;
            cnode_ff <= LCPB_RST_CAN_NODE;
            prate_ff <= LCPB_RST_PB_RATE;
            paddr_ff <= LCPB_RST_PB_ADDR;
        end
        else
        begin
            if (take_var)
                var_ff <= cfg.wdata;
            if (take_can)
            begin
                crate_ff <= w_crate;
                cnode_ff <= w_cnode;
            end
            if (take_pb)
            begin
                prate_ff <= w_prate;
                paddr_ff <= w_paddr;
            end
        end
    end

    assign cfg.gen_mode = mode_ff;
    assign cfg.gen_dir = dir_ff;
    assign cfg.gen_obj = obj_ff;
    assign cfg.gen_gap = gap_ff;
    assign cfg.var_sel = var_ff;
    assign cfg.can_rate = crate_ff;
    assign cfg.can_node = cnode_ff;
    assign cfg.pb_rate = prate_ff;
    assign cfg.pb_addr = paddr_ff;

    wire [31:0] gen_store_img = {mode_ff, dir_ff, obj_ff, gap_ff};

    // accepted general write lands every byte in its place
    property p_gen_store;
        @(posedge mclk_in) disable iff (!nrst_in)
        take_gen |=> (gen_store_img == $past(cfg.wdata));
    endproperty
    a_gen_store: assert property (p_gen_store)
        else $error("general record not stored as written");

    // refused write leaves every record unchanged
    property p_reject_keep;
        @(posedge mclk_in) disable iff (!nrst_in)
        !cfg.wr_ok |=> ($stable(gen_store_img) &&
            $stable(var_ff) && $stable({crate_ff, cnode_ff}) &&
            $stable({prate_ff, paddr_ff}));
    endproperty
    a_reject_keep: assert property (p_reject_keep)
        else $error("refused write changed a stored value");

    // station address always stays inside its range
    property p_pb_range;
        @(posedge mclk_in) disable iff (!nrst_in)
        take_pb |=> (paddr_ff >= LCPB_PB_ADDR_MIN) &&
            (paddr_ff <= LCPB_PB_ADDR_MAX) && (paddr_ff == $past(w_paddr));
    endproperty
    a_pb_range: assert property (p_pb_range)
        else $error("station address out of range or not stored");
endmodule

// File: core/lcpb_bank.sv
// apb front end and decoded outputs of the light curtain parameter bank
// What this block does
// - read-only cycle time 1000 in low half
// - 32-bit variant selector, default 1, codes 1-7
// - can record: rate in bits 15:8, node 1-127
// - can rate codes 0-3 give 1000..125 kbit/s
// - fieldbus rate codes 0-7, default 6
// - fieldbus record with station address 1-126
// - general record: four bytes at 24/16/8/0
// - beam mode parallel, diagonal or crossed
// - numbering direction from connector or opposite
// - object filter ignores short interrupted groups
// - gap filter ignores short free groups
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module lcpb_bank
    import lcpb_pkg::*;
(
    input wire logic mclk_in, // 50 MHz system clock
    input wire logic nrst_in, // async reset, active low
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb access phase
    input wire logic pwrite_in, // apb direction, high = write
    input wire logic [11:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    input wire logic [3:0] pstrb_in, // apb byte strobes
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error
    output logic [2:0] variant_code_out, // active interface variant
    output logic [6:0] can_node_out, // can node number
    output logic [10:0] can_kbps_out, // can bit rate, kbit/s
    output logic [6:0] pb_addr_out, // fieldbus station address
    output logic [21:0] pb_bps_out, // fieldbus bit rate, bit/s
    output logic [1:0] scan_mode_out, // 0 parallel 1 diagonal 2 crossed
    output logic count_inverted_out, // beams numbered from far end
    output logic [7:0] min_object_out, // least interrupted group
    output logic [7:0] min_gap_out // least free group
);
    lcpb_cfg_if cfg(); // link to the parameter store

    // parameter store holds the records and judges every write image
    lcpb_store u_store (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .cfg(cfg)
    );

    // address decode, one target per record word
    wire hit_cyc = (paddr_in == lcpb_byte_addr(LCPB_IDX_CYCLE));
    wire hit_gen = (paddr_in == lcpb_byte_addr(LCPB_IDX_GEN));
    wire hit_var = (paddr_in == lcpb_byte_addr(LCPB_IDX_VAR));
    wire hit_can = (paddr_in == lcpb_byte_addr(LCPB_IDX_CAN));
    wire hit_pb = (paddr_in == lcpb_byte_addr(LCPB_IDX_PB));
    lcpb_tgt_t tgt; // decoded target of the current access
    assign tgt = hit_cyc ? LCPB_TGT_CYC :
        hit_gen ? LCPB_TGT_GEN :
        hit_var ? LCPB_TGT_VAR :
        hit_can ? LCPB_TGT_CAN :
        hit_pb ? LCPB_TGT_PB : LCPB_TGT_NONE;

    // read images; unused upper bits read as zero
    wire [31:0] img_cyc = {16'h0000, LCPB_CYCLE_TIME};
    wire [31:0] img_gen = {cfg.gen_mode, cfg.gen_dir, cfg.gen_obj,
        cfg.gen_gap};
    wire [31:0] img_can = {16'h0000, cfg.can_rate, cfg.can_node};
    wire [31:0] img_pb = {16'h0000, cfg.pb_rate, cfg.pb_addr};
    wire [31:0] rd_word = (tgt == LCPB_TGT_CYC) ? img_cyc :
        (tgt == LCPB_TGT_GEN) ? img_gen :
        (tgt == LCPB_TGT_VAR) ? cfg.var_sel :
        (tgt == LCPB_TGT_CAN) ? img_can :
        (tgt == LCPB_TGT_PB) ? img_pb : 32'h0000_0000;

    // error: unmapped word, or write that is partial, read only or illegal
    wire part_wr = (pstrb_in != LCPB_STRB_ALL); // records only as whole
    wire bad_wr = pwrite_in && (part_wr || !cfg.wr_ok);
    wire acc_err = (tgt == LCPB_TGT_NONE) || bad_wr;

    // bus phase: one wait state so that every bus output is a flop
    lcpb_st_t st_ff, nxt_st;
    wire access = psel_in && penable_in;
    wire finish = access && (st_ff == LCPB_ST_ANSWER); // master sees ready
    assign nxt_st = (st_ff == LCPB_ST_IDLE) ?
        (access ? LCPB_ST_ANSWER : LCPB_ST_IDLE) :
        (access ? LCPB_ST_IDLE : LCPB_ST_ANSWER);

    // write request towards the store; commits at the finishing edge only
    assign cfg.wr_tgt = tgt;
    assign cfg.wdata = pwdata_in;
    assign cfg.wr_stb = finish && pwrite_in && !pslverr_out;

    // answer registers, captured in the first access cycle
    wire start = access && (st_ff == LCPB_ST_IDLE);
    wire [31:0] nxt_prdata = (start && !pwrite_in && !acc_err) ?
        rd_word : (finish ? 32'h0000_0000 : prdata_out);
    wire nxt_pslverr = start ? acc_err : (finish ? 1'b0 : pslverr_out);
    wire nxt_pready = (nxt_st == LCPB_ST_ANSWER);

    // bus state and answer flops
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_ff <= LCPB_ST_IDLE;
            prdata_out <= 32'h0000_0000;
            pslverr_out <= 1'b0;
            pready_out <= 1'b0;
        end
        else
        begin
            st_ff <= nxt_st;
            prdata_out <= nxt_prdata;
            pslverr_out <= nxt_pslverr;
            pready_out <= nxt_pready;
        end
    end

    // decoded settings handed to the link and evaluation logic
    wire [2:0] nxt_variant = cfg.var_sel[2:0];
    wire [6:0] nxt_can_node = cfg.can_node[6:0];
    wire [10:0] nxt_can_kbps = lcpb_can_kbps(cfg.can_rate);
    wire [6:0] nxt_pb_addr = cfg.pb_addr[6:0];
    wire [21:0] nxt_pb_bps = lcpb_pb_bps(cfg.pb_rate);
    wire [1:0] nxt_scan_mode = cfg.gen_mode[1:0];
    wire nxt_count_inv = cfg.gen_dir[0];
    wire [7:0] nxt_min_object = cfg.gen_obj;
    wire [7:0] nxt_min_gap = cfg.gen_gap;

    // output flops; settings reach the outputs one cycle after the store
    always_ff @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            variant_code_out <= LCPB_RST_VAR[2:0];
            can_node_out <= LCPB_RST_CAN_NODE[6:0];
            can_kbps_out <= lcpb_can_kbps(LCPB_RST_CAN_RATE);
            pb_addr_out <= LCPB_RST_PB_ADDR[6:0];
            pb_bps_out <= lcpb_pb_bps(LCPB_RST_PB_RATE);
            scan_mode_out <= LCPB_RST_MODE[1:0];
            count_inverted_out <= LCPB_RST_DIR[0];
            min_object_out <= LCPB_RST_OBJ;
            min_gap_out <= LCPB_RST_GAP;
        end
        else
        begin
            variant_code_out <= nxt_variant;
            can_node_out <= nxt_can_node;
            can_kbps_out <= nxt_can_kbps;
            pb_addr_out <= nxt_pb_addr;
            pb_bps_out <= nxt_pb_bps;
            scan_mode_out <= nxt_scan_mode;
            count_inverted_out <= nxt_count_inv;
            min_object_out <= nxt_min_object;
            min_gap_out <= nxt_min_gap;
        end
    end

    // cycle-time read always answers 1000 with upper half zero
    property p_cycle_read;
        @(posedge mclk_in) disable iff (!nrst_in)
        (finish && !pwrite_in && hit_cyc) |->
            (prdata_out == 32'h0000_03E8) && !pslverr_out;
    endproperty
    a_cycle_read: assert property (p_cycle_read)
        else $error("cycle time read wrong");

    // write to the cycle time is refused
    property p_cycle_ro;
        @(posedge mclk_in) disable iff (!nrst_in)
        (finish && pwrite_in && hit_cyc) |-> pslverr_out && !cfg.wr_stb;
    endproperty
    a_cycle_ro: assert property (p_cycle_ro)
        else $error("write to read-only cycle time not refused");

    // refused bus write leaves every stored record unchanged
    property p_refused_keep;
        @(posedge mclk_in) disable iff (!nrst_in)
        (finish && pwrite_in && pslverr_out) |=> ($stable(img_gen) &&
            $stable(cfg.var_sel) && $stable(img_can) && $stable(img_pb));
    endproperty
    a_refused_keep: assert property (p_refused_keep)
        else $error("refused bus write changed a stored value");

    // variant code above 7 or zero is answered with an error
    property p_variant_range;
        @(posedge mclk_in) disable iff (!nrst_in)
        (finish && pwrite_in && hit_var &&
            ((pwdata_in > 32'h0000_0007) || (pwdata_in == 32'h0000_0000)))
            |-> pslverr_out;
    endproperty
    a_variant_range: assert property (p_variant_range)
        else $error("illegal variant code accepted");

    // can record reads keep the node number legal and bits 31:16 zero
    property p_can_read;
        @(posedge mclk_in) disable iff (!nrst_in)
        (finish && !pwrite_in && hit_can) |->
            (prdata_out[31:16] == 16'h0000) &&
            (prdata_out[7:0] != 8'h00) && !prdata_out[7];
    endproperty
    a_can_read: assert property (p_can_read)
        else $error("can record read image wrong");

    // slowest can code reaches the rate output within two cycles
    property p_can_rate;
        @(posedge mclk_in) disable iff (!nrst_in)
        (cfg.can_rate == 8'h03) [*2] |-> (can_kbps_out == 11'h07D);
    endproperty
    a_can_rate: assert property (p_can_rate)
        else $error("can rate code 3 not decoded to 125");

    // default fieldbus code gives 1500 kbit/s one cycle later
    property p_pb_rate;
        @(posedge mclk_in) disable iff (!nrst_in)
        (cfg.pb_rate == LCPB_RST_PB_RATE) |=> (pb_bps_out == 22'h16E360);
    endproperty
    a_pb_rate: assert property (p_pb_rate)
        else $error("fieldbus rate code 6 not decoded");

    // beam mode output never leaves the three geometries
    property p_scan_mode;
        @(posedge mclk_in) disable iff (!nrst_in)
        ##1 (scan_mode_out != 2'b11);
    endproperty
    a_scan_mode: assert property (p_scan_mode)
        else $error("undefined beam mode driven");

    // direction bit follows the stored field one cycle later
    property p_count_dir;
        @(posedge mclk_in) disable iff (!nrst_in)
        $changed(cfg.gen_dir) |=>
            (count_inverted_out == $past(cfg.gen_dir[0]));
    endproperty
    a_count_dir: assert property (p_count_dir)
        else $error("numbering direction not followed");

    // both filter sizes stay at one or more
    property p_filters;
        @(posedge mclk_in) disable iff (!nrst_in)
        ##1 (min_object_out != 8'h00) && (min_gap_out != 8'h00);
    endproperty
    a_filters: assert property (p_filters)
        else $error("filter size of zero driven");

    // ready comes exactly one cycle after the access phase opens
    property p_one_wait;
        @(posedge mclk_in) disable iff (!nrst_in)
        start |=> pready_out ##1 !pready_out;
    endproperty
    a_one_wait: assert property (p_one_wait)
        else $error("ready not after one wait state");
endmodule

// File: tb/lcpb_apb_master.sv
// apb master standing in for the external parameter client
`timescale 1ns/100ps
module lcpb_apb_master (
    input wire logic mclk_in, // bus clock
    input wire logic pready_in, // slave ready
    input wire logic pslverr_in, // slave error
    input wire logic [31:0] prdata_in, // slave read data
    output logic psel_out = 1'b0, // select
    output logic penable_out = 1'b0, // access phase
    output logic pwrite_out = 1'b0, // high = write
    output logic [11:0] paddr_out = 12'h000, // byte address
    output logic [31:0] pwdata_out = 32'h0000_0000, // write data
    output logic [3:0] pstrb_out = 4'h0 // byte strobes
);
    // one transfer; request held until ready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] rd, output logic err);
        @(posedge mclk_in);
        psel_out <= 1'b1;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        pstrb_out <= s;
        @(posedge mclk_in);
        penable_out <= 1'b1;
        // waits for the slave; only the bench watchdog ends a dead wait
        do
        begin
            @(posedge mclk_in);
        end
        while (pready_in !== 1'b1);
        rd = prdata_in;
        err = pslverr_in;
        psel_out <= 1'b0;
        penable_out <= 1'b0;
    endtask
endmodule

// File: tb/lcpb_bank_tb.sv
// self-checking bench of the light curtain parameter bank
`timescale 1ns/100ps
module lcpb_bank_tb;
    import lcpb_pkg::*;
    localparam logic [11:0] A_CYC = 12'h110; // byte addr = 4 * index
    localparam logic [11:0] A_GEN = 12'h11C;
    localparam logic [11:0] A_VAR = 12'h168;
    localparam logic [11:0] A_CAN = 12'h16C;
    localparam logic [11:0] A_PB = 12'h170;
    logic mclk_in = 1'b0; // 50 MHz
    logic nrst_in = 1'b0; // held low at start
    logic psel, penable, pwrite, pready, pslverr, cnt_inv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic [2:0] var_code;
    logic [6:0] can_node, pb_addr;
    logic [10:0] can_kbps;
    logic [21:0] pb_bps;
    logic [1:0] scan_mode;
    logic [7:0] min_obj, min_gap;
    int fail_count = 0;
    int tests_run = 0;
    int can_tab [4] = '{1000, 500, 250, 125}; // kbit/s per code
    int pb_tab [8] = '{9600, 19200, 45450, 93750, 187500, 500000,
        1500000, 3000000}; // bit/s per code
    always #10 mclk_in = ~mclk_in;
    lcpb_apb_master M (.mclk_in(mclk_in), .pready_in(pready),
        .pslverr_in(pslverr), .prdata_in(prdata), .psel_out(psel),
        .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata), .pstrb_out(pstrb));
    lcpb_bank DUT (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr),
        .variant_code_out(var_code), .can_node_out(can_node),
        .can_kbps_out(can_kbps), .pb_addr_out(pb_addr),
        .pb_bps_out(pb_bps), .scan_mode_out(scan_mode),
        .count_inverted_out(cnt_inv), .min_object_out(min_obj),
        .min_gap_out(min_gap));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // whole-word access; decoded outputs settle two edges later
    task automatic acc(input logic w, input logic [11:0] a,
        input logic [31:0] d, input logic ee, input logic [31:0] er);
        logic [31:0] rd;
        logic err;
        M.xfer(w, a, d, LCPB_STRB_ALL, rd, err);
        chk({31'h0, err}, {31'h0, ee});
        if (!w)
        begin
            chk(rd, er);
        end
        repeat (2) @(posedge mclk_in);
    endtask
    // reset values, read-only word, unmapped place
    task automatic t_defaults();
        chk(32'(var_code), 32'h1);
        chk(32'(can_kbps), 32'(can_tab[0]));
        chk(32'(pb_bps), 32'(pb_tab[6]));
        chk(32'(can_node), 32'h0A);
        chk(32'(pb_addr), 32'h7E);
        chk({30'h0, scan_mode, cnt_inv}, 32'h0);
        chk({16'h0, min_obj, min_gap}, 32'h0101);
        acc(1'b1, A_CYC, 32'h5, 1'b1, 0);
        acc(1'b0, A_CYC, 0, 1'b0, 32'h3E8);
        acc(1'b0, A_GEN, 0, 1'b0, 32'h0101);
        acc(1'b0, A_VAR, 0, 1'b0, 32'h1);
        acc(1'b0, A_CAN, 0, 1'b0, 32'h000A);
        acc(1'b0, A_PB, 0, 1'b0, 32'h067E);
        acc(1'b0, 12'h004, 0, 1'b1, 0);
    endtask
    // every variant code, then both bounds refused
    task automatic t_variant();
        for (int c = 1; c <= 7; c++)
        begin
            acc(1'b1, A_VAR, 32'(c), 1'b0, 0);
            acc(1'b0, A_VAR, 0, 1'b0, 32'(c));
            chk(32'(var_code), 32'(c));
        end
        acc(1'b1, A_VAR, 32'h8, 1'b1, 0);
        acc(1'b1, A_VAR, 32'h0, 1'b1, 0);
        acc(1'b0, A_VAR, 0, 1'b0, 32'h7);
    endtask
    // can rates, node bounds, partial strobes
    task automatic t_can();
        logic [31:0] rd;
        logic err;
        for (int c = 0; c < 4; c++)
        begin
            acc(1'b1, A_CAN, {16'h0, 8'(c), 8'h7F}, 1'b0, 0);
            chk(32'(can_kbps), 32'(can_tab[c]));
            chk(32'(can_node), 32'h7F);
        end
        acc(1'b1, A_CAN, 32'hFFFF_0201, 1'b0, 0);
        acc(1'b1, A_CAN, 32'h0000_0080, 1'b1, 0);
        acc(1'b1, A_CAN, 32'h0000_0400, 1'b1, 0);
        M.xfer(1'b1, A_CAN, 32'h0000_0105, 4'h3, rd, err);
        chk({31'h0, err}, 32'h1);
        acc(1'b0, A_CAN, 0, 1'b0, 32'h0201);
        chk(32'(can_node), 32'h1);
    endtask
    // fieldbus rates and station address bounds
    task automatic t_pb();
        for (int c = 0; c < 8; c++)
        begin
            acc(1'b1, A_PB, {16'h0, 8'(c), 8'h01}, 1'b0, 0);
            chk(32'(pb_bps), 32'(pb_tab[c]));
        end
        acc(1'b1, A_PB, 32'h0000_037E, 1'b0, 0);
        acc(1'b1, A_PB, 32'h0000_037F, 1'b1, 0);
        acc(1'b1, A_PB, 32'h0000_0801, 1'b1, 0);
        acc(1'b0, A_PB, 0, 1'b0, 32'h037E);
        chk(32'(pb_addr), 32'h7E);
    endtask
    // beam modes, direction, filters, each field refused
    task automatic t_gen();
        for (int m = 0; m < 3; m++)
        begin
            acc(1'b1, A_GEN, {8'(m), 8'(m % 2), 8'hFF, 8'(m + 1)}, 1'b0,
                0);
            chk({30'h0, scan_mode}, 32'(m));
            chk({31'h0, cnt_inv}, 32'(m % 2));
            chk(32'(min_obj), 32'hFF);
            chk(32'(min_gap), 32'(m + 1));
        end
        acc(1'b1, A_GEN, 32'h0300_0101, 1'b1, 0);
        acc(1'b1, A_GEN, 32'h0002_0101, 1'b1, 0);
        acc(1'b1, A_GEN, 32'h0000_0001, 1'b1, 0);
        acc(1'b1, A_GEN, 32'h0000_0100, 1'b1, 0);
        acc(1'b0, A_GEN, 0, 1'b0, 32'h0200_FF03);
    endtask
    // reset in mid-run brings the variant, general and fieldbus records back to their defaults
    task automatic t_reset();
        nrst_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        chk(32'(var_code), 32'h1);
        chk({16'h0, min_obj, min_gap}, 32'h0101);
        acc(1'b0, A_GEN, 0, 1'b0, 32'h0101);
        acc(1'b0, A_PB, 0, 1'b0, 32'h067E);
    endtask
    // verdict and end of run
    task automatic final_report();
        if (fail_count == 0 && tests_run > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge mclk_in);
        nrst_in <= 1'b1;
        t_defaults();
        t_variant();
        t_can();
        t_pb();
        t_gen();
        t_reset();
        final_report();
    end
    // watchdog, well beyond the few hundred cycles the tests need
    initial
    begin
        repeat (5000) @(posedge mclk_in);
        fail_count++;
        final_report();
    end
endmodule
